// ===== rtl/conv_ctrl_regs.svh
// timings in ns, bit positions, keys and reset values of the control core
`ifndef CONV_CTRL_REGS_SVH
`define CONV_CTRL_REGS_SVH
`define CLK_PERIOD_NS     20
`define CONV_T_9K6_NS     104170
`define CONV_T_4K8_NS     208330
`define CONV_T_20SPS_NS   50000000
`define RDY_HOLD_NS       24000
`define PIPE_T_NS         20000
`define SWITCH_T_NS       10000
`define RESET_T_NS        100000
`define SLEW_TICK_NS      5000
`define KEY_ONE           16'h15FA
`define KEY_TWO           16'hAF51
`define LATCH_RESTART_BIT 0
`define LATCH_SUPPLY_BIT  1
`define LATCH_MODEM_BIT   2
`define SUPPLY_CALMEM_BIT 0
`define DAC_RESET_CODE    14'h0000
`define RESULT_RESET      16'h0000
`define SLEW_STEP_SHIFT   2
`endif

// ===== rtl/conv_ctrl_pkg.sv
// enumerations of the conversion control core
package conv_ctrl_pkg;
	typedef enum logic [1:0] {
		SEQ_IDLE_CMD = 2'b00,
		SEQ_SINGLE   = 2'b01,
		SEQ_CONT     = 2'b10,
		SEQ_PWRDN    = 2'b11
	} conv_seq_e;
	typedef enum logic [1:0] {
		RATE_9K6   = 2'b00,
		RATE_4K8   = 2'b01,
		RATE_20SPS = 2'b10
	} rate_e;
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_PIPE   = 2'b01,
		ST_CONV   = 2'b10,
		ST_SWITCH = 2'b11
	} seq_state_e;
endpackage : conv_ctrl_pkg

// ===== rtl/pin_sync.sv
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module pin_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pin_in,
	output logic      level_out
);
	logic q1;
	logic q2;
	logic q3;

	// q1 feeds q2 only; metastability stays in the first stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q1        <= RESET_VAL;
			q2        <= RESET_VAL;
			q3        <= RESET_VAL;
			level_out <= RESET_VAL;
		end else begin
			q1 <= pin_in;
			q2 <= q1;
			q3 <= q2;
			if (q2 == q3) begin
				level_out <= q3;
			end
		end
	end
endmodule : pin_sync

// ===== rtl/conv_slew_reset_alert_ctrl.sv
// conversion sequencer, output code slewing, reset sources and latched faults
`timescale 1ns/10ps
`include "conv_ctrl_regs.svh"

// What this block does
// - conversion-done pin goes low when a sequence finishes, single or continuous.
// - host writing one to the ready flag releases the done pin.
// - in continuous mode the done pin releases itself 24 us later.
// - any write to conversion control releases the done pin.
// - one input converted continuously gives done edges one conversion period apart.
// - pipeline delay before first conversion, switch interval between inputs.
// - diagnostics share one rate; mains rejection only at the slowest rate.
// - source select maps a measurement per diagnostic; host enables it first.
// - a 14-bit target code drives the output, direct or slewed.
// - present code register always shows the code applied to the converter.
// - linear slewing moves toward target by step size at each rate tick.
// - slewing off applies a new target at once.
// - slewing turned off mid-way holds the present code.
// - separate enhanced slew mode has its own enable bit.
// - any reset restores defaults, reloads calibration, sets high impedance.
// - reset starts from the reset pin or an armed thermal trip.
// - software reset needs key 0x15FA then key 0xAF51, in order.
// - restart flag is set when a reset cycle completes.
// - a host transfer during the reset cycle sets the trim memory fault.
// - any fault sets its latched bit; only an unmasked latched bit asserts the fault pin.
// - writing one clears a latched bit; 0xFFFF clears all.
// - results copy into result registers as the done pin asserts.
// - a stop during continuous conversion waits for the sequence end.
module conv_slew_reset_alert_ctrl #(
	parameter int CONV_9K6_CYC   = `CONV_T_9K6_NS / `CLK_PERIOD_NS,
	parameter int CONV_4K8_CYC   = `CONV_T_4K8_NS / `CLK_PERIOD_NS,
	parameter int CONV_20SPS_CYC = `CONV_T_20SPS_NS / `CLK_PERIOD_NS,
	parameter int RESET_CYC      = `RESET_T_NS / `CLK_PERIOD_NS
) (
	// clock and reset
	input  wire logic        SYS_CLK_IN,
	input  wire logic        RSTN_IN,
	// reset sources
	input  wire logic        HW_RESET_N_IN,
	input  wire logic        THERM_TRIP_IN,
	input  wire logic        THERM_RST_EN_IN,
	input  wire logic        KEY_WR_IN,
	input  wire logic [15:0] KEY_IN,
	input  wire logic        HOST_XFER_IN,
	// conversion control
	input  wire logic        CONV_CTRL_WR_IN,
	input  wire logic [1:0]  CONV_SEQ_IN,
	input  wire logic [5:0]  CONV_EN_IN,
	input  wire logic [1:0]  DIAG_RATE_IN,
	input  wire logic [1:0]  CH_RATE_IN,
	input  wire logic        DIAG_SRC_WR_IN,
	input  wire logic [15:0] DIAG_SRC_IN,
	input  wire logic        RDY_CLR_WR_IN,
	input  wire logic [15:0] ADC_DATA_IN,
	// output code control
	input  wire logic        TARGET_WR_IN,
	input  wire logic [13:0] TARGET_CODE_IN,
	input  wire logic        SLEW_LIN_EN_IN,
	input  wire logic [1:0]  SLEW_STEP_IN,
	input  wire logic [1:0]  SLEW_RATE_IN,
	input  wire logic        ENH_SLEW_EN_IN,
	input  wire logic        CHAN_FUNC_WR_IN,
	// fault inputs and clears
	input  wire logic [15:0] FAULT_EVENT_IN,
	input  wire logic [7:0]  SUPPLY_EVENT_IN,
	input  wire logic [7:0]  MODEM_EVENT_IN,
	input  wire logic [15:0] FAULT_MASK_IN,
	input  wire logic        LATCH_CLR_WR_IN,
	input  wire logic        SUPPLY_CLR_WR_IN,
	input  wire logic        MODEM_CLR_WR_IN,
	input  wire logic [15:0] CLR_DATA_IN,
	// converter side
	output logic             ADC_RDY_N_OUT,
	output logic             ADC_BUSY_OUT,
	output logic [2:0]       ADC_SEL_OUT,
	output logic [3:0]       DIAG_SRC_OUT,
	output logic             REJECT_50_60_OUT,
	output logic [15:0]      CHANNEL_RESULT_FIRST_OUT,
	output logic [15:0]      CHANNEL_RESULT_SECOND_OUT,
	output logic [63:0]      DIAGNOSTIC_RESULT_OUT,
	// output code side
	output logic [13:0]      TARGET_CODE_OUT,
	output logic [13:0]      DAC_CODE_OUT,
	output logic             ENH_SLEW_OUT,
	output logic             CHANNEL_HIZ_OUT,
	// reset and faults
	output logic             CAL_RELOAD_OUT,
	output logic             FAULT_N_OUT,
	output logic [15:0]      FAULT_LATCH_OUT,
	output logic [7:0]       SUPPLY_STATUS_OUT,
	output logic [7:0]       MODEM_STATUS_OUT
);
	localparam int CW        = 22;
	localparam int PIPE_CYC  = `PIPE_T_NS / `CLK_PERIOD_NS;
	localparam int SW_CYC    = `SWITCH_T_NS / `CLK_PERIOD_NS;
	localparam int HOLD_CYC  = `RDY_HOLD_NS / `CLK_PERIOD_NS;
	localparam int TICK_CYC  = `SLEW_TICK_NS / `CLK_PERIOD_NS;

	if (CONV_20SPS_CYC >= (1 << CW) || CONV_9K6_CYC < 1 || CONV_4K8_CYC < 1 ||
		RESET_CYC < 2 || RESET_CYC >= (1 << CW)) begin : bad_params
		$error("conversion or reset count out of range");
	end

	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RSTN_IN);

	// ************************************************************
	// reset cycle
	// ************************************************************
	logic          hw_rst_n;
	logic          therm;
	logic          rst_busy;
	logic [CW-1:0] rst_cnt;
	logic          key1_seen;
	logic          soft_req;
	logic          rst_req;
	logic          rst_done;

	pin_sync #(.RESET_VAL(1'h1)) u_rst_pin (.clk(SYS_CLK_IN), .rst_n(RSTN_IN),
		.pin_in(HW_RESET_N_IN), .level_out(hw_rst_n));
	pin_sync #(.RESET_VAL(1'h0)) u_therm (.clk(SYS_CLK_IN), .rst_n(RSTN_IN),
		.pin_in(THERM_TRIP_IN), .level_out(therm));

	assign rst_req  = !hw_rst_n || (therm && THERM_RST_EN_IN) || soft_req;
	assign rst_done = rst_busy && !rst_req && rst_cnt == CW'(RESET_CYC - 1);

	// key pair, any other key disarms
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			key1_seen <= 1'h0;
			soft_req  <= 1'h0;
		end else begin
			soft_req <= KEY_WR_IN && !rst_busy && key1_seen && KEY_IN == `KEY_TWO;
			if (rst_busy) begin
				key1_seen <= 1'h0;
			end else if (KEY_WR_IN) begin
				key1_seen <= KEY_IN == `KEY_ONE;
			end
		end
	end

	// reset cycle, starts busy so power-up reloads calibration too
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			rst_busy <= 1'h1;
			rst_cnt  <= '0;
		end else if (rst_req) begin
			rst_busy <= 1'h1;
			rst_cnt  <= '0;
		end else if (rst_busy) begin
			rst_busy <= !rst_done;
			rst_cnt  <= rst_cnt + CW'(1);
		end
	end

	// calibration reload and high impedance channel
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			CAL_RELOAD_OUT  <= 1'h1;
			CHANNEL_HIZ_OUT <= 1'h1;
		end else begin
			CAL_RELOAD_OUT <= rst_busy && !rst_done;
			if (rst_busy) begin
				CHANNEL_HIZ_OUT <= 1'h1;
			end else if (CHAN_FUNC_WR_IN) begin
				CHANNEL_HIZ_OUT <= 1'h0;
			end
		end
	end

	// ************************************************************
	// conversion sequencer
	// ************************************************************
	conv_ctrl_pkg::seq_state_e state;
	logic [CW-1:0] cnt;
	logic [2:0]    idx;
	logic [5:0]    en_lat;
	logic          cont;
	logic          stop_pend;
	logic [1:0]    diag_rate;
	logic [15:0]   diag_src;
	logic [15:0]   shadow [6];
	logic [15:0]   res [6];
	logic [10:0]   rdy_cnt;
	logic          rdy_auto;
	logic [3:0]    nxt;
	logic          conv_end;
	logic          seq_end;
	logic          ctrl_wr;
	logic          stop_cmd;
	logic          start_ok;

	function automatic logic [CW-1:0] conv_len(input logic [1:0] r);
		unique case (r)
			conv_ctrl_pkg::RATE_9K6:   conv_len = CW'(CONV_9K6_CYC);
			conv_ctrl_pkg::RATE_20SPS: conv_len = CW'(CONV_20SPS_CYC);
			default:                   conv_len = CW'(CONV_4K8_CYC);
		endcase
	endfunction : conv_len

	// lowest enabled input above from, as {found, index}; from 4'hF scans them all
	function automatic logic [3:0] next_en(input logic [5:0] en, input logic [3:0] from);
		next_en = 4'h0;
		for (int i = 5; i >= 0; i--) begin
			if ((from == 4'hF || i > int'(from)) && en[i]) begin
				next_en = {1'h1, 3'(i)};
			end
		end
	endfunction : next_en

	function automatic logic [CW-1:0] len_of(input logic [2:0] i);
		len_of = (i < 3'h2) ? conv_len(CH_RATE_IN) : conv_len(diag_rate);
	endfunction : len_of

	assign ctrl_wr  = CONV_CTRL_WR_IN && !rst_busy;
	assign start_ok = CONV_SEQ_IN == conv_ctrl_pkg::SEQ_SINGLE ||
		CONV_SEQ_IN == conv_ctrl_pkg::SEQ_CONT;
	assign stop_cmd = ctrl_wr && !start_ok && state != conv_ctrl_pkg::ST_IDLE;
	assign nxt      = next_en(en_lat, {1'h0, idx});
	assign conv_end = state == conv_ctrl_pkg::ST_CONV && cnt == '0 && !rst_busy;
	assign seq_end  = conv_end && !nxt[3];

	// diagnostic rate and source select held from host writes
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			diag_rate <= conv_ctrl_pkg::RATE_9K6;
			diag_src  <= '0;
		end else if (rst_busy) begin
			diag_rate <= conv_ctrl_pkg::RATE_9K6;
			diag_src  <= '0;
		end else begin
			if (ctrl_wr) begin
				diag_rate <= DIAG_RATE_IN;
			end
			if (DIAG_SRC_WR_IN) begin
				diag_src <= DIAG_SRC_IN;
			end
		end
	end

	// pipeline first, switch interval between inputs
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			state  <= conv_ctrl_pkg::ST_IDLE;
			cnt    <= '0;
			idx    <= 3'h0;
			en_lat <= 6'h00;
			cont   <= 1'h0;
		end else if (rst_busy) begin
			state  <= conv_ctrl_pkg::ST_IDLE;
			cnt    <= '0;
			idx    <= 3'h0;
			en_lat <= 6'h00;
			cont   <= 1'h0;
		end else begin
			unique case (state)
				conv_ctrl_pkg::ST_IDLE: begin
					if (ctrl_wr && start_ok && |CONV_EN_IN) begin
						en_lat <= CONV_EN_IN;
						cont   <= CONV_SEQ_IN == conv_ctrl_pkg::SEQ_CONT;
						idx    <= next_en(CONV_EN_IN, 4'hF)[2:0];
						cnt    <= CW'(PIPE_CYC - 1);
						state  <= conv_ctrl_pkg::ST_PIPE;
					end
				end
				conv_ctrl_pkg::ST_PIPE, conv_ctrl_pkg::ST_SWITCH: begin
					if (cnt == '0) begin
						cnt   <= len_of(idx) - CW'(1);
						state <= conv_ctrl_pkg::ST_CONV;
					end else begin
						cnt <= cnt - CW'(1);
					end
				end
				conv_ctrl_pkg::ST_CONV: begin
					if (cnt != '0) begin
						cnt <= cnt - CW'(1);
					end else if (nxt[3]) begin
						idx   <= nxt[2:0];
						cnt   <= CW'(SW_CYC - 1);
						state <= conv_ctrl_pkg::ST_SWITCH;
					end else if (!cont || stop_pend || stop_cmd) begin
						state <= conv_ctrl_pkg::ST_IDLE;
					// lone input restarts with no switch gap
					end else if (next_en(en_lat, 4'hF)[2:0] == idx) begin
						cnt <= len_of(idx) - CW'(1);
					end else begin
						idx   <= next_en(en_lat, 4'hF)[2:0];
						cnt   <= CW'(SW_CYC - 1);
						state <= conv_ctrl_pkg::ST_SWITCH;
					end
				end
			endcase
		end
	end

	// remember a stop until the sequence ends
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			stop_pend <= 1'h0;
		end else begin
			stop_pend <= !rst_busy && state != conv_ctrl_pkg::ST_IDLE && !seq_end &&
				(stop_pend || stop_cmd);
		end
	end

	// results copied at the sequence end, same edge as the done pin
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			for (int i = 0; i < 6; i++) begin
				shadow[i] <= `RESULT_RESET;
				res[i]    <= `RESULT_RESET;
			end
		end else if (rst_busy) begin
			for (int i = 0; i < 6; i++) begin
				shadow[i] <= `RESULT_RESET;
				res[i]    <= `RESULT_RESET;
			end
		end else begin
			if (conv_end) begin
				shadow[idx] <= ADC_DATA_IN;
			end
			for (int i = 0; i < 6; i++) begin
				if (seq_end && en_lat[i]) begin
					res[i] <= (3'(i) == idx) ? ADC_DATA_IN : shadow[i];
				end
			end
		end
	end

	// done pin, a finishing sequence beats any release
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			ADC_RDY_N_OUT <= 1'h1;
			rdy_cnt       <= 11'h000;
			rdy_auto      <= 1'h0;
		end else if (rst_busy) begin
			ADC_RDY_N_OUT <= 1'h1;
			rdy_cnt       <= 11'h000;
			rdy_auto      <= 1'h0;
		end else if (seq_end) begin
			ADC_RDY_N_OUT <= 1'h0;
			rdy_cnt       <= 11'(HOLD_CYC - 1);
			rdy_auto      <= cont;
		end else begin
			if (rdy_cnt != 11'h000) begin
				rdy_cnt <= rdy_cnt - 11'h001;
			end
			if (RDY_CLR_WR_IN || ctrl_wr || (rdy_auto && rdy_cnt == 11'h000)) begin
				ADC_RDY_N_OUT <= 1'h1;
			end
		end
	end

	// converter steering, rejection flag only at the slow rate
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			ADC_BUSY_OUT     <= 1'h0;
			ADC_SEL_OUT      <= 3'h0;
			DIAG_SRC_OUT     <= 4'h0;
			REJECT_50_60_OUT <= 1'h0;
		end else begin
			ADC_BUSY_OUT     <= state != conv_ctrl_pkg::ST_IDLE;
			ADC_SEL_OUT      <= idx;
			DIAG_SRC_OUT     <= (idx < 3'h2) ? 4'h0 : diag_src[4 * (idx - 3'h2) +: 4];
			REJECT_50_60_OUT <= diag_rate == conv_ctrl_pkg::RATE_20SPS;
		end
	end

	assign CHANNEL_RESULT_FIRST_OUT  = res[0];
	assign CHANNEL_RESULT_SECOND_OUT = res[1];
	assign DIAGNOSTIC_RESULT_OUT     = {res[5], res[4], res[3], res[2]};

	// ************************************************************
	// output code path
	// ************************************************************
	logic [13:0] step;
	logic [11:0] tick_cnt;
	logic        tick;

	assign step = 14'h0001 << (`SLEW_STEP_SHIFT * SLEW_STEP_IN);
	assign tick = tick_cnt == 12'h000;

	// update rate divider, period doubles per rate code
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			tick_cnt <= 12'h000;
		end else if (tick || !SLEW_LIN_EN_IN) begin
			tick_cnt <= 12'((TICK_CYC << SLEW_RATE_IN) - 1);
		end else begin
			tick_cnt <= tick_cnt - 12'h001;
		end
	end

	// target, applied code and enhanced slew bit
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			TARGET_CODE_OUT <= `DAC_RESET_CODE;
			DAC_CODE_OUT    <= `DAC_RESET_CODE;
			ENH_SLEW_OUT    <= 1'h0;
		end else if (rst_busy) begin
			TARGET_CODE_OUT <= `DAC_RESET_CODE;
			DAC_CODE_OUT    <= `DAC_RESET_CODE;
			ENH_SLEW_OUT    <= 1'h0;
		end else begin
			ENH_SLEW_OUT <= ENH_SLEW_EN_IN;
			if (TARGET_WR_IN) begin
				TARGET_CODE_OUT <= TARGET_CODE_IN;
			end
			if (!SLEW_LIN_EN_IN) begin
				if (TARGET_WR_IN) begin
					DAC_CODE_OUT <= TARGET_CODE_IN;
				end
			// clamp the last step onto the target
			end else if (tick && DAC_CODE_OUT < TARGET_CODE_OUT) begin
				DAC_CODE_OUT <= (TARGET_CODE_OUT - DAC_CODE_OUT <= step) ?
					TARGET_CODE_OUT : DAC_CODE_OUT + step;
			end else if (tick && DAC_CODE_OUT > TARGET_CODE_OUT) begin
				DAC_CODE_OUT <= (DAC_CODE_OUT - TARGET_CODE_OUT <= step) ?
					TARGET_CODE_OUT : DAC_CODE_OUT - step;
			end
		end
	end

	// ************************************************************
	// fault latches
	// ************************************************************
	logic [15:0] latch_set;

	// summary bits re-set while a detail bit stays set
	always_comb begin
		latch_set = FAULT_EVENT_IN;
		latch_set[`LATCH_RESTART_BIT] = rst_done;
		latch_set[`LATCH_SUPPLY_BIT]  = |SUPPLY_STATUS_OUT;
		latch_set[`LATCH_MODEM_BIT]   = |MODEM_STATUS_OUT;
	end

	// set beats clear, start of reset wipes them
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			FAULT_LATCH_OUT   <= 16'h0000;
			SUPPLY_STATUS_OUT <= 8'h00;
			MODEM_STATUS_OUT  <= 8'h00;
			FAULT_N_OUT       <= 1'h1;
		end else if (rst_req) begin
			FAULT_LATCH_OUT   <= 16'h0000;
			SUPPLY_STATUS_OUT <= 8'h00;
			MODEM_STATUS_OUT  <= 8'h00;
			FAULT_N_OUT       <= 1'h1;
		end else begin
			FAULT_LATCH_OUT <= latch_set | (FAULT_LATCH_OUT &
				~((LATCH_CLR_WR_IN && !rst_busy) ? CLR_DATA_IN : 16'h0000));
			SUPPLY_STATUS_OUT <= SUPPLY_EVENT_IN |
				(8'(HOST_XFER_IN && rst_busy) << `SUPPLY_CALMEM_BIT) |
				(SUPPLY_STATUS_OUT &
				~((SUPPLY_CLR_WR_IN && !rst_busy) ? CLR_DATA_IN[7:0] : 8'h00));
			MODEM_STATUS_OUT <= MODEM_EVENT_IN | (MODEM_STATUS_OUT &
				~((MODEM_CLR_WR_IN && !rst_busy) ? CLR_DATA_IN[7:0] : 8'h00));
			FAULT_N_OUT <= !(|(FAULT_LATCH_OUT & ~FAULT_MASK_IN));
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	sequence reset_ends_s;
		rst_busy ##1 !rst_busy;
	endsequence
	sequence key_two_s;
		KEY_WR_IN && KEY_IN == `KEY_TWO && key1_seen && !rst_busy;
	endsequence

	rdy_on_done_a: assert property (seq_end |=> !ADC_RDY_N_OUT)
		else $error("done pin not asserted at sequence end");
	rdy_release_a: assert property (RDY_CLR_WR_IN && !seq_end |=> ADC_RDY_N_OUT)
		else $error("ready flag write did not release done pin");
	rdy_auto_a: assert property (!ADC_RDY_N_OUT && rdy_auto && rdy_cnt == 11'h000 && !seq_end
		|=> ADC_RDY_N_OUT)
		else $error("continuous done pin not released");
	ctrl_release_a: assert property (ctrl_wr && !seq_end |=> ADC_RDY_N_OUT)
		else $error("control write did not release done pin");
	copy_result_a: assert property (seq_end |=> res[$past(idx)] == $past(ADC_DATA_IN))
		else $error("result not copied at sequence end");
	stop_wait_a: assert property (stop_cmd && !conv_end && cont
		|=> state != conv_ctrl_pkg::ST_IDLE)
		else $error("stop cut the sequence short");
	direct_code_a: assert property (!SLEW_LIN_EN_IN && TARGET_WR_IN && !rst_busy
		|=> DAC_CODE_OUT == $past(TARGET_CODE_IN))
		else $error("direct code not applied");
	hold_code_a: assert property (!SLEW_LIN_EN_IN && !TARGET_WR_IN && !rst_busy
		|=> $stable(DAC_CODE_OUT))
		else $error("code moved with slewing off");
	no_overshoot_a: assert property (SLEW_LIN_EN_IN && !rst_busy && DAC_CODE_OUT <= TARGET_CODE_OUT
		|=> DAC_CODE_OUT <= $past(TARGET_CODE_OUT))
		else $error("slew passed the target");
	soft_reset_a: assert property (key_two_s |-> ##3 CAL_RELOAD_OUT)
		else $error("key pair did not reset");
	restart_flag_a: assert property (reset_ends_s |-> FAULT_LATCH_OUT[`LATCH_RESTART_BIT])
		else $error("restart flag missing after reset");
	calmem_flag_a: assert property (HOST_XFER_IN && rst_busy && !rst_req
		|=> SUPPLY_STATUS_OUT[`SUPPLY_CALMEM_BIT])
		else $error("early transfer not flagged");
	fault_pin_a: assert property (|(FAULT_LATCH_OUT & ~FAULT_MASK_IN) && !rst_req
		|=> !FAULT_N_OUT)
		else $error("fault pin idle with unmasked bit");
endmodule : conv_slew_reset_alert_ctrl

// ===== testbench/host_model.sv
// host controller model: command key writes and bare serial transfers
`timescale 1ns/10ps
module host_model (
	// clock
	input  wire logic        clk_in,
	// host requests
	output logic             key_wr_out,
	output logic [15:0]      key_out,
	output logic             xfer_out
);
	// idle host: strobes low, key bus parked on a value that is no key
	initial begin
		key_wr_out = 1'b0;
		key_out    = 16'h0000;
		xfer_out   = 1'b0;
	end
	// one key write per call
	// key bus flips after the strobe so a stale key never looks held
	task automatic send_key(input logic [15:0] k);
		@(posedge clk_in);
		key_wr_out <= 1'b1;
		key_out    <= k;
		@(posedge clk_in);
		key_wr_out <= 1'b0;
		key_out    <= ~k;
	endtask : send_key
	// one transfer pulse, legal or not depending on when it comes
	task automatic xfer();
		@(posedge clk_in);
		xfer_out <= 1'b1;
		@(posedge clk_in);
		xfer_out <= 1'b0;
	endtask : xfer
endmodule : host_model

// ===== testbench/test_conv_slew_reset_alert_ctrl.sv
// self-checking bench of the conversion, slew, reset and fault core
`timescale 1ns/10ps
module test_conv_slew_reset_alert_ctrl;
	logic SYS_CLK_IN = 0, RSTN_IN = 0, HW_RESET_N_IN = 1, THERM_TRIP_IN = 0;
	logic THERM_RST_EN_IN = 0, KEY_WR_IN, HOST_XFER_IN, CONV_CTRL_WR_IN = 0;
	logic DIAG_SRC_WR_IN = 0, RDY_CLR_WR_IN = 0, TARGET_WR_IN = 0;
	logic SLEW_LIN_EN_IN = 0, ENH_SLEW_EN_IN = 0, CHAN_FUNC_WR_IN = 0;
	logic LATCH_CLR_WR_IN = 0, SUPPLY_CLR_WR_IN = 0, MODEM_CLR_WR_IN = 0;
	logic [1:0] CONV_SEQ_IN = 0, DIAG_RATE_IN = 0, CH_RATE_IN = 0;
	logic [1:0] SLEW_STEP_IN = 0, SLEW_RATE_IN = 0;
	logic [5:0] CONV_EN_IN = 0;
	logic [7:0] SUPPLY_EVENT_IN = 0, MODEM_EVENT_IN = 0, SUPPLY_STATUS_OUT, MODEM_STATUS_OUT;
	logic [13:0] TARGET_CODE_IN = 0, TARGET_CODE_OUT, DAC_CODE_OUT;
	logic [15:0] KEY_IN, DIAG_SRC_IN = 0, ADC_DATA_IN = 16'hA5C3, FAULT_EVENT_IN = 0;
	logic [15:0] FAULT_MASK_IN = 0, CLR_DATA_IN = 0, FAULT_LATCH_OUT;
	logic [15:0] CHANNEL_RESULT_FIRST_OUT, CHANNEL_RESULT_SECOND_OUT;
	logic [63:0] DIAGNOSTIC_RESULT_OUT;
	logic [3:0] DIAG_SRC_OUT;
	logic [2:0] ADC_SEL_OUT;
	logic ADC_RDY_N_OUT, ADC_BUSY_OUT, REJECT_50_60_OUT, ENH_SLEW_OUT;
	logic CHANNEL_HIZ_OUT, CAL_RELOAD_OUT, FAULT_N_OUT;
	int num_errors = 0;
	int samples_checked = 0;
	int n;

	// 50 MHz system clock
	always #10 SYS_CLK_IN = ~SYS_CLK_IN;

	// short counts keep the run brief
	conv_slew_reset_alert_ctrl #(.CONV_9K6_CYC(20), .CONV_4K8_CYC(40), .CONV_20SPS_CYC(1500),
		.RESET_CYC(30)) conv_slew_reset_alert_ctrl_inst (.*);
	host_model host_model_inst (.clk_in(SYS_CLK_IN), .key_wr_out(KEY_WR_IN),
		.key_out(KEY_IN), .xfer_out(HOST_XFER_IN));

	// one comparison of a result value, widened to 16 bits
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	// wait k edges, then step past them so outputs have settled
	task automatic cyc(input int k);
		repeat (k) @(posedge SYS_CLK_IN);
		#1;
	endtask : cyc

	// single place where the run ends
	task automatic results();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : results

	// hang guard, well past the expected few thousand cycles
	initial begin
		#400000;
		num_errors++;
		results();
	end

	initial begin
		repeat (6) @(posedge SYS_CLK_IN);
		RSTN_IN <= 1'b1;
		repeat (100) if (CAL_RELOAD_OUT !== 1'b0) cyc(1);
		check(FAULT_LATCH_OUT[0], 1, "restart flag");
		check(CHANNEL_HIZ_OUT, 1, "high impedance");
		@(posedge SYS_CLK_IN) {LATCH_CLR_WR_IN, CLR_DATA_IN} <= {1'b1, 16'hFFFF};
		@(posedge SYS_CLK_IN) LATCH_CLR_WR_IN <= 1'b0;
		cyc(3);
		check(FAULT_LATCH_OUT, 0, "clear all");
		// single conversion of channel one at the fastest rate
		@(posedge SYS_CLK_IN) {CONV_CTRL_WR_IN, CONV_SEQ_IN, CONV_EN_IN} <= {1'b1, 2'b01, 6'h01};
		@(posedge SYS_CLK_IN) CONV_CTRL_WR_IN <= 1'b0;
		n = 1;
		repeat (1200) if (ADC_RDY_N_OUT !== 1'b0) begin cyc(1); n++; end
		check(n >= 1020, 1, "pipeline delay");
		check(ADC_RDY_N_OUT, 0, "done low");
		check(CHANNEL_RESULT_FIRST_OUT, 16'hA5C3, "result copy");
		@(posedge SYS_CLK_IN) RDY_CLR_WR_IN <= 1'b1;
		@(posedge SYS_CLK_IN) RDY_CLR_WR_IN <= 1'b0;
		cyc(2);
		check(ADC_RDY_N_OUT, 1, "ready clear");
		// continuous channel one at the slow rate: auto release, spacing, stop
		@(posedge SYS_CLK_IN) {CH_RATE_IN, DIAG_RATE_IN, ADC_DATA_IN} <= {4'hA, 16'h3C5A};
		@(posedge SYS_CLK_IN) {CONV_CTRL_WR_IN, CONV_SEQ_IN} <= 3'b110;
		@(posedge SYS_CLK_IN) CONV_CTRL_WR_IN <= 1'b0;
		cyc(2);
		check({ADC_BUSY_OUT, REJECT_50_60_OUT, ADC_SEL_OUT}, 5'h18, "slow busy");
		repeat (3000) if (ADC_RDY_N_OUT !== 1'b0) cyc(1);
		check(CHANNEL_RESULT_FIRST_OUT, 16'h3C5A, "continuous copy");
		n = 0;
		repeat (2000) if (ADC_RDY_N_OUT === 1'b0) begin cyc(1); n++; end
		check(n, 1200, "auto release");
		repeat (2000) if (ADC_RDY_N_OUT !== 1'b0) begin cyc(1); n++; end
		check(n, 1500, "done spacing");
		@(posedge SYS_CLK_IN) {CONV_CTRL_WR_IN, CONV_SEQ_IN} <= 3'b100;
		@(posedge SYS_CLK_IN) CONV_CTRL_WR_IN <= 1'b0;
		cyc(2);
		check(ADC_RDY_N_OUT, 1, "control release");
		check(ADC_BUSY_OUT, 1, "stop deferred");
		repeat (2000) if (ADC_BUSY_OUT !== 1'b0) cyc(1);
		check(ADC_RDY_N_OUT, 0, "last sequence done");
		// direct code, then slewed with a final step shorter than 64
		@(posedge SYS_CLK_IN) {TARGET_WR_IN, TARGET_CODE_IN} <= {1'b1, 14'h0100};
		@(posedge SYS_CLK_IN) TARGET_WR_IN <= 1'b0;
		cyc(1);
		check(DAC_CODE_OUT, 16'h0100, "direct code");
		@(posedge SYS_CLK_IN) {SLEW_LIN_EN_IN, SLEW_STEP_IN} <= 3'b111;
		@(posedge SYS_CLK_IN) {TARGET_WR_IN, TARGET_CODE_IN} <= {1'b1, 14'h0110};
		@(posedge SYS_CLK_IN) TARGET_WR_IN <= 1'b0;
		cyc(300);
		check(DAC_CODE_OUT, 16'h0110, "clamped step");
		// latched fault and its write-one clear
		@(posedge SYS_CLK_IN) FAULT_EVENT_IN <= 16'h0020;
		@(posedge SYS_CLK_IN) FAULT_EVENT_IN <= 16'h0000;
		cyc(3);
		check(FAULT_LATCH_OUT, 16'h0020, "latched bit");
		check(FAULT_N_OUT, 0, "fault pin");
		// clearing the summary before the modem status does not stick
		@(posedge SYS_CLK_IN) {MODEM_EVENT_IN, CLR_DATA_IN} <= {8'h04, 16'h0004};
		@(posedge SYS_CLK_IN) {MODEM_EVENT_IN, LATCH_CLR_WR_IN} <= 9'h001;
		@(posedge SYS_CLK_IN) {LATCH_CLR_WR_IN, MODEM_CLR_WR_IN} <= 2'b01;
		@(posedge SYS_CLK_IN) MODEM_CLR_WR_IN <= 1'b0;
		cyc(1);
		check({MODEM_STATUS_OUT, FAULT_LATCH_OUT[7:0]}, 16'h0024, "summary held");
		@(posedge SYS_CLK_IN) {LATCH_CLR_WR_IN, CLR_DATA_IN} <= {1'b1, 16'h0024};
		@(posedge SYS_CLK_IN) LATCH_CLR_WR_IN <= 1'b0;
		cyc(3);
		check(FAULT_N_OUT, 1, "fault released");
		// software reset by key pair, host traffic while it runs
		host_model_inst.send_key(16'h15FA);
		host_model_inst.send_key(16'hAF51);
		cyc(2);
		check(CAL_RELOAD_OUT, 1, "key reset");
		host_model_inst.xfer();
		repeat (100) if (CAL_RELOAD_OUT !== 1'b0) cyc(1);
		cyc(2);
		check(SUPPLY_STATUS_OUT[0], 1, "trim fault");
		check(DAC_CODE_OUT, 0, "code default");
		// channel function and masking, then pin and armed thermal resets
		@(posedge SYS_CLK_IN) FAULT_MASK_IN <= 16'hFFFF;
		@(posedge SYS_CLK_IN) {CHAN_FUNC_WR_IN, ENH_SLEW_EN_IN} <= 2'b11;
		@(posedge SYS_CLK_IN) {CHAN_FUNC_WR_IN, HW_RESET_N_IN} <= 2'b00;
		cyc(3);
		check({CHANNEL_HIZ_OUT, ENH_SLEW_OUT, FAULT_N_OUT}, 3'b011, "function set");
		@(posedge SYS_CLK_IN) HW_RESET_N_IN <= 1'b1;
		cyc(4);
		check({CAL_RELOAD_OUT, CHANNEL_HIZ_OUT, ENH_SLEW_OUT}, 3'b110, "pin reset");
		repeat (100) if (CAL_RELOAD_OUT !== 1'b0) cyc(1);
		@(posedge SYS_CLK_IN) THERM_TRIP_IN <= 1'b1;
		cyc(8);
		check(CAL_RELOAD_OUT, 0, "unarmed trip");
		@(posedge SYS_CLK_IN) THERM_RST_EN_IN <= 1'b1;
		cyc(3);
		check(CAL_RELOAD_OUT, 1, "thermal reset");
		results();
	end
endmodule : test_conv_slew_reset_alert_ctrl
